// file: design/lac_pkg.sv
// Constants, field layouts and carrier types of the latch acknowledge controller.
// Assumes a 250 MHz pclk and an APB slave with 32-bit data and byte addresses.
package lac_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 250_000_000;
   localparam int unsigned LONG_PRESS_MS  = 1000;
   localparam int unsigned LED_PHASE_MS   = 1000;
   localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
   localparam int unsigned LED_PHASE_CYC  = LED_PHASE_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W          = 32;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W          = 8;
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_ALARM_CFG   = 8'h04;
   localparam logic [7:0]  REG_CMD         = 8'h08;
   localparam logic [7:0]  REG_LED_STAT    = 8'h0C;
   localparam logic [7:0]  REG_RELAY_STAT  = 8'h10;
   localparam logic [7:0]  REG_MISC_STAT   = 8'h14;

   // CTRL fields and reset values
   localparam int unsigned CTRL_PERMIT_BIT = 0;
   localparam int unsigned CTRL_MODE_LSB   = 1;
   localparam logic        CTRL_PERMIT_RST = 1'b0;

   // CMD fields (write one to fire)
   localparam int unsigned CMD_SYS_BIT     = 0;
   localparam int unsigned CMD_LEDS_BIT    = 1;
   localparam int unsigned CMD_RELAYS_BIT  = 2;
   localparam int unsigned CMD_SCADA_BIT   = 3;
   localparam int unsigned CMD_TRIP_BIT    = 4;
   localparam int unsigned CMD_ALL_BIT     = 5;
   localparam int unsigned CMD_SG_LSB      = 8;
   localparam int unsigned SG_IDX_W        = 3;

   // MISC_STAT fields
   localparam int unsigned MISC_SCADA_LSB  = 0;
   localparam int unsigned MISC_TRIP_LSB   = 8;
   localparam int unsigned MISC_SYS_BIT    = 16;
   localparam int unsigned MISC_MENU_BIT   = 17;
   localparam int unsigned MISC_AUTH_BIT   = 18;
   localparam int unsigned MISC_RED_BIT    = 19;
   localparam int unsigned MISC_GREEN_BIT  = 20;
   localparam int unsigned MAX_GROUP       = 8;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LP_NOTHING     = 3'h0,
      LP_LEDS_NOPW   = 3'h1,
      LP_LEDS        = 3'h2,
      LP_LEDS_RELAYS = 3'h3,
      LP_ALL         = 3'h4
   } lac_lp_mode_t;

   localparam lac_lp_mode_t CTRL_MODE_RST = LP_LEDS_NOPW;

   typedef struct packed {
      logic sys;
      logic leds;
      logic relays;
      logic scada;
      logic trips;
   } lac_clr_t;

   typedef struct packed {
      logic     clear_key;
      logic     edit_mode;
      logic     nav_open;
      logic     confirm;
      logic     cancel;
      lac_clr_t sel;
   } lac_panel_t;

   typedef struct packed {
      logic granted;
      logic denied;
      logic first_protection_access_level_empty;
   } lac_auth_t;

endpackage : lac_pkg

// file: design/lac_ctrl.sv
// Latch acknowledge controller: latched LEDs, relays, SCADA signals, trip commands.
// Assumes all inputs synchronous to pclk; APB master keeps psel/penable protocol.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module lac_ctrl #(
   parameter int unsigned N_LEDS            = 16,
   parameter int unsigned N_RELAYS          = 16,
   parameter int unsigned N_SCADA           = 8,
   parameter int unsigned N_SG              = 4,
   parameter int unsigned LONG_PRESS_CYCLES = lac_pkg::LONG_PRESS_CYC,
   parameter int unsigned LED_PHASE_CYCLES  = lac_pkg::LED_PHASE_CYC
) (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [lac_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Sources that set the latches, and relay off-delay completion that releases relay latches
   input  wire logic [N_LEDS-1:0]          led_src,
   input  wire logic [N_RELAYS-1:0]        relay_src,
   input  wire logic [N_RELAYS-1:0]        relay_off_delay_done,
   input  wire logic [N_SCADA-1:0]         scada_src,
   input  wire logic [N_SG-1:0]            trip_src,
   input  wire logic                       sys_warn_src,
   // Assigned acknowledge inputs and alarm
   input  wire logic                       clear_all_outputs_input,
   input  wire logic                       clear_leds_input,
   input  wire logic                       clear_scada_input,
   input  wire logic                       prot_alarm,
   // Operator panel and authorisation
   input  wire lac_pkg::lac_panel_t        panel,
   input  wire lac_pkg::lac_auth_t         auth,
   // Latched indications
   output logic      [N_LEDS-1:0]          led_latched,
   output logic      [N_RELAYS-1:0]        relay_latched,
   output logic      [N_SCADA-1:0]         scada_latched,
   output logic      [N_SG-1:0]            trip_latched,
   output logic                            sys_warn_latched,
   // Panel feedback
   output logic                            menu_open,
   output logic                            auth_request,
   output logic                            led_test_red,
   output logic                            led_test_green
);

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   generate
      if (N_LEDS < 1 || N_LEDS > 32 || N_RELAYS < 1 || N_RELAYS > 32)
         $error("lac_ctrl: LED and relay counts must be 1 to 32");
      if (N_SCADA < 1 || N_SCADA > lac_pkg::MAX_GROUP || N_SG < 1 || N_SG > lac_pkg::MAX_GROUP)
         $error("lac_ctrl: SCADA and switchgear counts must be 1 to 8");
      if (LONG_PRESS_CYCLES < 2 || LED_PHASE_CYCLES < 1)
         $error("lac_ctrl: timing counts too small");
   endgenerate

   localparam logic [lac_pkg::CNT_W-1:0] LONG_LAST  = lac_pkg::CNT_W'(LONG_PRESS_CYCLES - 1);
   localparam logic [lac_pkg::CNT_W-1:0] PHASE_LAST = lac_pkg::CNT_W'(LED_PHASE_CYCLES - 1);

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_HELD = 5'h02,
      ST_MENU = 5'h04,
      ST_AUTH = 5'h08,
      ST_WREL = 5'h10
   } lac_state_t;

   // Decode a switchgear index into a one-hot trip mask
   function automatic logic [N_SG-1:0] sg_onehot(input logic [lac_pkg::SG_IDX_W-1:0] idx);
      logic [N_SG-1:0] m;
      m = '0;
      for (int i = 0; i < N_SG; i++) begin
         if (idx == lac_pkg::SG_IDX_W'(i)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : sg_onehot

   // Long-press categories for a mode setting
   function automatic lac_pkg::lac_clr_t lp_mask(input lac_pkg::lac_lp_mode_t mode);
      lac_pkg::lac_clr_t m;
      m = '0;
      case (mode)
         lac_pkg::LP_LEDS_NOPW,
         lac_pkg::LP_LEDS:        m.leds = 1'b1;
         lac_pkg::LP_LEDS_RELAYS: begin
            m.leds   = 1'b1;
            m.relays = 1'b1;
         end
         lac_pkg::LP_ALL: begin
            m.leds   = 1'b1;
            m.relays = 1'b1;
            m.scada  = 1'b1;
            m.trips  = 1'b1;
         end
         default:                 m = '0;
      endcase
      return m;
   endfunction : lp_mask

   // ---------------------------------------------------------------
   // APB register file
   // ---------------------------------------------------------------
   logic                       remote_permit;
   lac_pkg::lac_lp_mode_t      lp_mode;
   logic [N_LEDS-1:0]          alarm_cfg;
   logic                       apb_access;
   logic                       apb_wr;
   logic                       apb_cmd;
   logic [31:0]                next_prdata;
   logic                       next_err;

   assign apb_access = psel & penable & pready;
   assign apb_wr     = apb_access & pwrite;
   assign apb_cmd    = apb_wr & (paddr == lac_pkg::REG_CMD);

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err    = 1'b0;
      case (paddr)
         lac_pkg::REG_CTRL: begin
            next_prdata[lac_pkg::CTRL_PERMIT_BIT] = remote_permit;
            next_prdata[lac_pkg::CTRL_MODE_LSB +: 3] = lp_mode;
         end
         lac_pkg::REG_ALARM_CFG:  next_prdata[N_LEDS-1:0] = alarm_cfg;
         lac_pkg::REG_CMD:        next_prdata = 32'h0000_0000;
         lac_pkg::REG_LED_STAT:   next_prdata[N_LEDS-1:0] = led_latched;
         lac_pkg::REG_RELAY_STAT: next_prdata[N_RELAYS-1:0] = relay_latched;
         lac_pkg::REG_MISC_STAT: begin
            next_prdata[lac_pkg::MISC_SCADA_LSB +: N_SCADA] = scada_latched;
            next_prdata[lac_pkg::MISC_TRIP_LSB +: N_SG]     = trip_latched;
            next_prdata[lac_pkg::MISC_SYS_BIT]   = sys_warn_latched;
            next_prdata[lac_pkg::MISC_MENU_BIT]  = menu_open;
            next_prdata[lac_pkg::MISC_AUTH_BIT]  = auth_request;
            next_prdata[lac_pkg::MISC_RED_BIT]   = led_test_red;
            next_prdata[lac_pkg::MISC_GREEN_BIT] = led_test_green;
         end
         default:                 next_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= next_err;
      end else begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_permit <= lac_pkg::CTRL_PERMIT_RST;
         lp_mode       <= lac_pkg::CTRL_MODE_RST;
         alarm_cfg     <= '0;
      end else if (apb_wr && paddr == lac_pkg::REG_CTRL) begin
         remote_permit <= pwdata[lac_pkg::CTRL_PERMIT_BIT];
         lp_mode       <= lac_pkg::lac_lp_mode_t'(pwdata[lac_pkg::CTRL_MODE_LSB +: 3]);
      end else if (apb_wr && paddr == lac_pkg::REG_ALARM_CFG) begin
         alarm_cfg     <= pwdata[N_LEDS-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Edge detection of assigned inputs
   // ---------------------------------------------------------------
   logic [3:0] in_q;
   logic [3:0] in_rise;
   logic       key_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_q  <= 4'h0;
         key_q <= 1'b0;
      end else begin
         in_q  <= {prot_alarm, clear_scada_input, clear_leds_input, clear_all_outputs_input};
         key_q <= panel.clear_key;
      end
   end

   assign in_rise = {prot_alarm, clear_scada_input, clear_leds_input, clear_all_outputs_input} & ~in_q;

   // ---------------------------------------------------------------
   // Panel clear key and acknowledge menu
   // ---------------------------------------------------------------
   lac_state_t                 state;
   logic [lac_pkg::CNT_W-1:0]  hold_cnt;
   lac_pkg::lac_clr_t          pend;
   lac_pkg::lac_clr_t          apply_m;
   lac_pkg::lac_clr_t          long_m;
   lac_pkg::lac_clr_t          sel_pw;
   logic                       key_rise;
   logic                       lv1_empty;

   assign key_rise  = panel.clear_key & ~key_q;
   assign lv1_empty = auth.first_protection_access_level_empty;
   assign long_m    = lp_mask(lp_mode);
   assign sel_pw    = panel.sel & ~lac_pkg::lac_clr_t'(5'h10);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt <= '0;
      end else if (state == ST_HELD) begin
         hold_cnt <= hold_cnt + 1'b1;
      end else begin
         hold_cnt <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= ST_IDLE;
         pend    <= '0;
         apply_m <= '0;
      end else begin
         apply_m <= '0;
         case (state)
            ST_IDLE: begin
               if (key_rise && !panel.edit_mode) begin
                  state <= ST_HELD;
               end else if (panel.nav_open) begin
                  state <= ST_MENU;
               end
            end
            ST_HELD: begin
               if (!panel.clear_key) begin
                  state <= ST_MENU;
               end else if (hold_cnt == LONG_LAST) begin
                  if (lp_mode == lac_pkg::LP_LEDS_NOPW || (long_m != '0 && lv1_empty)) begin
                     apply_m <= long_m;
                     state   <= ST_WREL;
                  end else if (long_m != '0) begin
                     pend  <= long_m;
                     state <= ST_AUTH;
                  end else begin
                     state <= ST_WREL;
                  end
               end
            end
            ST_MENU: begin
               if (panel.cancel) begin
                  state <= ST_IDLE;
               end else if (panel.confirm) begin
                  if (sel_pw != '0 && !lv1_empty) begin
                     pend  <= panel.sel;
                     state <= ST_AUTH;
                  end else begin
                     apply_m <= panel.sel;
                     state   <= ST_IDLE;
                  end
               end
            end
            ST_AUTH: begin
               if (auth.granted) begin
                  apply_m <= pend;
                  state   <= panel.clear_key ? ST_WREL : ST_IDLE;
               end else if (auth.denied) begin
                  state <= panel.clear_key ? ST_WREL : ST_IDLE;
               end
            end
            ST_WREL: begin
               if (!panel.clear_key) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign menu_open    = state[2];
   assign auth_request = state[3];

   // ---------------------------------------------------------------
   // Clear request collection
   // ---------------------------------------------------------------
   lac_pkg::lac_clr_t          rem_m;
   logic [N_SG-1:0]            rem_trip;
   logic [N_LEDS-1:0]          clr_leds;
   logic [N_SG-1:0]            clr_trip;
   logic                       clr_relays;
   logic                       clr_scada;
   logic                       clr_sys;
   logic [lac_pkg::SG_IDX_W-1:0] cmd_sg;

   assign cmd_sg = pwdata[lac_pkg::CMD_SG_LSB +: lac_pkg::SG_IDX_W];

   always_comb begin
      rem_m    = '0;
      rem_trip = '0;
      if (apb_cmd) begin
         rem_m.sys    = pwdata[lac_pkg::CMD_SYS_BIT];
         rem_m.leds   = pwdata[lac_pkg::CMD_LEDS_BIT] | pwdata[lac_pkg::CMD_ALL_BIT];
         rem_m.relays = pwdata[lac_pkg::CMD_RELAYS_BIT] | pwdata[lac_pkg::CMD_ALL_BIT];
         rem_m.scada  = pwdata[lac_pkg::CMD_SCADA_BIT] | pwdata[lac_pkg::CMD_ALL_BIT];
         rem_m.trips  = pwdata[lac_pkg::CMD_ALL_BIT];
         if (pwdata[lac_pkg::CMD_TRIP_BIT]) begin
            rem_trip = sg_onehot(cmd_sg);
         end
      end
      rem_m.relays = rem_m.relays | in_rise[0];
      rem_m.leds   = rem_m.leds | in_rise[1];
      rem_m.scada  = rem_m.scada | in_rise[2];
      if (!remote_permit) begin
         rem_m    = '0;
         rem_trip = '0;
      end
   end

   always_comb begin
      clr_leds = {N_LEDS{apply_m.leds | rem_m.leds}};
      if (remote_permit && in_rise[3]) begin
         clr_leds = clr_leds | alarm_cfg;
      end
      clr_relays = apply_m.relays | rem_m.relays;
      clr_scada  = apply_m.scada | rem_m.scada;
      clr_sys    = apply_m.sys | rem_m.sys;
      clr_trip   = {N_SG{apply_m.trips | rem_m.trips}} | rem_trip;
   end

   // ---------------------------------------------------------------
   // Latches: a new set always wins over a clear
   // ---------------------------------------------------------------
   logic [N_RELAYS-1:0] relay_ack;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_latched <= '0;
      end else begin
         led_latched <= led_src | (led_latched & ~clr_leds);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scada_latched    <= '0;
         trip_latched     <= '0;
         sys_warn_latched <= 1'b0;
      end else begin
         scada_latched    <= scada_src | (scada_latched & ~{N_SCADA{clr_scada}});
         trip_latched     <= trip_src | (trip_latched & ~clr_trip);
         sys_warn_latched <= sys_warn_src | (sys_warn_latched & ~clr_sys);
      end
   end

   // Relay acknowledge is held until the off-delay lets the latch go
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_latched <= '0;
         relay_ack     <= '0;
      end else begin
         relay_latched <= relay_src | (relay_latched & ~(relay_ack & relay_off_delay_done));
         relay_ack     <= (relay_ack | {N_RELAYS{clr_relays}}) & relay_latched
                          & ~(relay_ack & relay_off_delay_done & ~relay_src);
      end
   end

   // ---------------------------------------------------------------
   // LED test after every LED clear
   // ---------------------------------------------------------------
   logic [lac_pkg::CNT_W-1:0] test_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_cnt       <= '0;
         led_test_red   <= 1'b0;
         led_test_green <= 1'b0;
      end else if (|clr_leds) begin
         test_cnt       <= '0;
         led_test_red   <= 1'b1;
         led_test_green <= 1'b0;
      end else if (led_test_red | led_test_green) begin
         if (test_cnt == PHASE_LAST) begin
            test_cnt       <= '0;
            led_test_green <= led_test_red;
            led_test_red   <= 1'b0;
         end else begin
            test_cnt <= test_cnt + 1'b1;
         end
      end
   end

endmodule : lac_ctrl

// file: sim/lac_ctrl_props.sv
// Port checker for the latch acknowledge controller.
// Assumes it is bound into every lac_ctrl instance.
`timescale 1ns/1ns
module lac_ctrl_props #(
   parameter int unsigned N_LEDS   = 16,
   parameter int unsigned N_RELAYS = 16
) (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // APB
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // Latches and panel
   input wire logic [N_LEDS-1:0]   led_src,
   input wire logic [N_LEDS-1:0]   led_latched,
   input wire logic [N_RELAYS-1:0] relay_src,
   input wire logic [N_RELAYS-1:0] relay_off_delay_done,
   input wire logic [N_RELAYS-1:0] relay_latched,
   input wire lac_pkg::lac_panel_t panel,
   input wire logic                menu_open,
   input wire logic                led_test_red,
   input wire logic                led_test_green
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access; $rose(psel && penable); endsequence
   sequence s_red_run; led_test_red [*8]; endsequence
   property p_one_wait; s_access |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready not in second access cycle");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_idle_data; !pready |-> prdata == 32'h0; endproperty
   a_idle_data: assert property (p_idle_data) else $error("prdata not zero outside answer");
   property p_unmapped; pready && paddr > 8'h14 |-> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
   property p_led_set; led_src[0] |=> led_latched[0]; endproperty
   a_led_set: assert property (p_led_set) else $error("active source lost led latch");
   property p_relay_hold; relay_latched[0] && !relay_off_delay_done[0] && !relay_src[0] |=> relay_latched[0];
   endproperty
   a_relay_hold: assert property (p_relay_hold) else $error("relay released before off delay");
   property p_edit; panel.edit_mode && !panel.nav_open && !menu_open |=> !menu_open; endproperty
   a_edit: assert property (p_edit) else $error("clear key acted in edit mode");
   property p_red; $rose(led_test_red) |-> !led_test_green ##0 s_red_run; endproperty
   a_red: assert property (p_red) else $error("red test phase too short");
   property p_green; $fell(led_test_red) |-> led_test_green; endproperty
   a_green: assert property (p_green) else $error("green phase does not follow red");
endmodule : lac_ctrl_props
bind lac_ctrl lac_ctrl_props #(.N_LEDS(N_LEDS), .N_RELAYS(N_RELAYS)) i_lac_ctrl_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .led_src(led_src), .led_latched(led_latched),
   .relay_src(relay_src), .relay_off_delay_done(relay_off_delay_done), .relay_latched(relay_latched),
   .panel(panel), .menu_open(menu_open), .led_test_red(led_test_red), .led_test_green(led_test_green));

// file: sim/lac_panel_model.sv
// Operator panel model: clear key presses, menu confirm and cancel.
// Assumes the controller clock; changes keys just after rising edges.
`timescale 1ns/1ns
module lac_panel_model (
   // Clock
   input wire logic           pclk,
   // Panel keys
   output lac_pkg::lac_panel_t panel
);
   initial panel = '0;
   task automatic press(input int n, input logic ed);
      @(posedge pclk) panel.edit_mode <= ed;
      panel.clear_key <= 1'b1;
      repeat (n) @(posedge pclk);
      panel.clear_key <= 1'b0;
      panel.edit_mode <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : press
   task automatic cancel_menu;
      @(posedge pclk) panel.cancel <= 1'b1;
      @(posedge pclk) panel.cancel <= 1'b0;
   endtask : cancel_menu
   task automatic confirm_menu(input lac_pkg::lac_clr_t s);
      @(posedge pclk) panel.sel <= s;
      panel.confirm <= 1'b1;
      @(posedge pclk) panel.confirm <= 1'b0;
   endtask : confirm_menu
endmodule : lac_panel_model

// file: sim/test_latch_acknowledge_control.sv
// Self-checking bench of the latch acknowledge controller.
// Assumes shortened long-press and LED phase counts.
`timescale 1ns/1ns
module test_latch_acknowledge_control;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, v;
   logic pready, pslverr, e, sys_warn_src = 1'b0, cao = 1'b0, cli = 1'b0, csi = 1'b0, alarm = 1'b0;
   logic [15:0] led_src = '0, relay_src = '0, rdd = '0, led_l, rly_l, exp_led, mask;
   logic [7:0] scada_src = '0, scada_l;
   logic [3:0] trip_src = '0, trip_l;
   logic sys_l, menu_open, auth_req, red, green;
   lac_pkg::lac_panel_t panel;
   lac_pkg::lac_auth_t auth = '0;
   int n_fail = 0, compares = 0, cyc = 0;
   always #2 pclk = ~pclk;
   lac_ctrl #(.LONG_PRESS_CYCLES(20), .LED_PHASE_CYCLES(10)) i_lac_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .led_src(led_src), .relay_src(relay_src),
      .relay_off_delay_done(rdd), .scada_src(scada_src), .trip_src(trip_src), .sys_warn_src(sys_warn_src),
      .clear_all_outputs_input(cao), .clear_leds_input(cli), .clear_scada_input(csi), .prot_alarm(alarm),
      .panel(panel), .auth(auth), .led_latched(led_l), .relay_latched(rly_l), .scada_latched(scada_l),
      .trip_latched(trip_l), .sys_warn_latched(sys_l), .menu_open(menu_open), .auth_request(auth_req),
      .led_test_red(red), .led_test_green(green));
   lac_panel_model i_lac_panel_model (.pclk(pclk), .panel(panel));
   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk) psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic leds_on(input logic [15:0] m);
      @(posedge pclk) led_src <= m;
      @(posedge pclk) led_src <= '0;
   endtask : leds_on
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      v = $urandom(37);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h00, 0); chk(r, 32'h2);
      apb(0, 8'h20, 0); chk({31'h0, e}, 32'h1);
      v = $urandom;
      exp_led = v[15:0] | 16'h1;
      leds_on(exp_led);
      apb(1, 8'h08, 32'h2);
      apb(0, 8'h0C, 0); chk(r, {16'h0, exp_led});
      apb(1, 8'h00, 32'h3);
      apb(1, 8'h08, 32'h2);
      @(negedge pclk) chk({31'h0, red}, 32'h1);
      apb(0, 8'h0C, 0); chk(r, 32'h0);
      v = $urandom;
      @(posedge pclk) relay_src <= v[15:0] | 16'h1;
      scada_src <= v[23:16];
      @(posedge pclk) relay_src <= '0;
      scada_src <= '0;
      cao <= 1'b1;
      csi <= 1'b1;
      apb(0, 8'h10, 0); chk(r, {16'h0, v[15:0] | 16'h1});
      @(posedge pclk) rdd <= 16'hFFFF;
      apb(0, 8'h10, 0); chk(r, 32'h0);
      @(posedge pclk) trip_src <= 4'hF;
      scada_src <= 8'hA5;
      sys_warn_src <= 1'b1;
      @(posedge pclk) trip_src <= 4'h0;
      scada_src <= 8'h00;
      sys_warn_src <= 1'b0;
      apb(1, 8'h08, 32'h211);
      @(negedge pclk) chk({19'h0, sys_l, trip_l, scada_l}, 32'hBA5);
      apb(1, 8'h08, 32'h20);
      @(negedge pclk) chk({19'h0, sys_l, trip_l, scada_l}, 32'h0);
      repeat (12) @(negedge pclk);
      chk({30'h0, red, green}, 32'h1);
      v = $urandom;
      mask = v[15:0];
      apb(1, 8'h04, {16'h0, mask});
      leds_on(16'hFFFF);
      @(posedge pclk) alarm <= 1'b1;
      apb(0, 8'h0C, 0); chk(r, {16'h0, ~mask});
      i_lac_panel_model.press(25, 1'b1);
      apb(0, 8'h0C, 0); chk(r, {16'h0, ~mask});
      i_lac_panel_model.press(25, 1'b0);
      apb(0, 8'h0C, 0); chk(r, 32'h0);
      apb(1, 8'h00, 32'h1);
      leds_on(16'hFFFF);
      i_lac_panel_model.press(25, 1'b0);
      apb(0, 8'h0C, 0); chk(r, 32'hFFFF);
      i_lac_panel_model.press(3, 1'b0);
      @(negedge pclk) chk({31'h0, menu_open}, 32'h1);
      i_lac_panel_model.cancel_menu();
      apb(0, 8'h0C, 0); chk(r, 32'hFFFF);
      apb(1, 8'h00, 32'h9);
      i_lac_panel_model.press(25, 1'b0);
      @(negedge pclk) chk({15'h0, auth_req, led_l}, 32'h1FFFF);
      @(posedge pclk) auth.granted <= 1'b1;
      @(posedge pclk) auth.granted <= 1'b0;
      apb(0, 8'h0C, 0); chk(r, 32'h0);
      leds_on(16'hFFFF);
      @(posedge pclk) auth.first_protection_access_level_empty <= 1'b1;
      i_lac_panel_model.press(3, 1'b0);
      i_lac_panel_model.confirm_menu(5'h08);
      apb(0, 8'h0C, 0); chk(r, 32'h0);
      finish_test();
   end
endmodule : test_latch_acknowledge_control
